// ### pkg/lrrp_pkg.sv
// Constants and types for the long-range register page.
// Assumes a 100 MHz clock and an AXI4-Lite master with 32-bit data.
package lrrp_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Bus geometry: printed offsets are word indices, byte address = 4*idx
   localparam int ADDR_W = 9;
   localparam int IDX_W = 7;
   localparam int BYTE_W = 8;
   localparam int FIFO_DEPTH = 16;

   localparam logic [IDX_W-1:0] IDX_FIFO = 7'h00;
   localparam logic [IDX_W-1:0] IDX_OPMODE = 7'h01;
   localparam logic [IDX_W-1:0] IDX_RSV_LO = 7'h02;
   localparam logic [IDX_W-1:0] IDX_RSV_HI = 7'h05;
   localparam logic [IDX_W-1:0] IDX_FRF_HI = 7'h06;
   localparam logic [IDX_W-1:0] IDX_FRF_LO = 7'h08;
   localparam logic [IDX_W-1:0] IDX_PAGE_LO = 7'h0D;
   localparam logic [IDX_W-1:0] IDX_PAGE_HI = 7'h3F;
   localparam logic [IDX_W-1:0] IDX_BAND_LO = 7'h61;
   localparam logic [IDX_W-1:0] IDX_BAND_HI = 7'h73;

   localparam int PAGE_N = 51;
   localparam int PAGE_AW = 6;
   localparam int BAND_N = 19;
   localparam int BAND_AW = 5;
   localparam int FRF_N = 3;

   ////////////////////////////////////////////////////////////////////////
   // Operating-mode field layout and reset values
   localparam int OPM_FAMILY_BIT = 7;
   localparam int OPM_SHARED_BIT = 6;
   localparam int OPM_BAND_BIT = 3;
   localparam int OPM_STATE_MSB = 2;

   localparam logic FAMILY_RST = 1'b0;
   localparam logic SHARED_RST = 1'b0;
   localparam logic BAND_RST = 1'b1;
   localparam logic [BYTE_W-1:0] FRF_HI_RST = 8'h6C;
   localparam logic [BYTE_W-1:0] FRF_MID_RST = 8'h80;
   localparam logic [BYTE_W-1:0] FRF_LO_RST = 8'h00;
   localparam logic [BYTE_W-1:0] PAGE_RST = 8'h00;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Encodings are fixed by the host-visible field
   typedef enum logic [2:0] {
      ST_SLEEP = 3'h0,
      ST_STANDBY = 3'h1,
      ST_TX_SYNTH = 3'h2,
      ST_TRANSMIT = 3'h3,
      ST_RX_SYNTH = 3'h4,
      ST_RX_CONT = 3'h5,
      ST_RX_SINGLE = 3'h6,
      ST_CAD = 3'h7
   } lrrp_state_t;

   localparam lrrp_state_t STATE_RST = ST_STANDBY;

   typedef enum logic [2:0] {
      K_NONE = 3'h0,
      K_FIFO = 3'h1,
      K_OPMODE = 3'h2,
      K_RSV = 3'h3,
      K_FRF = 3'h4,
      K_PAGE = 3'h5,
      K_BAND = 3'h6
   } lrrp_kind_t;

   typedef struct packed {
      logic modem_family_select;
      logic shared_page_window_enable;
      logic band_bank_select;
      lrrp_state_t op_state;
      logic [23:0] carrier_freq;
   } lrrp_cfg_t;

endpackage

// ### rtl/lrrp_regs.sv
// Register page of the long-range modem with its payload FIFOs.
// Assumes an AXI4-Lite master and modem stream logic on the same clock.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module lrrp_fifo
   import lrrp_pkg::*;
#(
   parameter int WIDTH = BYTE_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   input wire logic flush,
   // Fill side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // Drain side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [0:DEPTH-1];
   logic [PW-1:0] wr_ptr_r;
   logic [PW-1:0] rd_ptr_r;
   logic [PW:0] count_r;
   logic push;
   logic pop;

   assign in_ready = (count_r != (PW+1)'(DEPTH)) && !flush;
   assign out_valid = (count_r != '0) && !flush;
   assign out_data = mem_r[rd_ptr_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else if (flush) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////
module lrrp_regs
   import lrrp_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // AXI4-Lite write address and data
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Payload toward the modem
   output logic [BYTE_W-1:0] pay_tx_data,
   output logic pay_tx_valid,
   input wire logic pay_tx_ready,
   // Payload from the modem
   input wire logic [BYTE_W-1:0] pay_rx_data,
   input wire logic pay_rx_valid,
   output logic pay_rx_ready,
   // Configuration seen by the radio
   output lrrp_cfg_t cfg,
   output logic state_change
);
   ////////////////////////////////////////////////////////////////////////
   // Control state
   logic family_r;
   logic shared_r;
   logic band_r;
   lrrp_state_t state_r;
   logic state_change_r;
   logic [BYTE_W-1:0] frf_r [0:1][0:FRF_N-1];
   logic [BYTE_W-1:0] page_r [0:1][0:PAGE_N-1];
   logic [BYTE_W-1:0] band_mem_r [0:1][0:BAND_N-1];

   logic sleeping;
   logic page_sel;

   assign sleeping = (state_r == ST_SLEEP);
   // FSK page in FSK mode, or in long-range mode with window open
   assign page_sel = !family_r || shared_r;

   function automatic lrrp_kind_t decode(input logic [IDX_W-1:0] idx);
      lrrp_kind_t k;
      k = K_NONE;
      if (idx == IDX_FIFO) begin
         k = K_FIFO;
      end else if (idx == IDX_OPMODE) begin
         k = K_OPMODE;
      end else if (idx >= IDX_RSV_LO && idx <= IDX_RSV_HI) begin
         k = K_RSV;
      end else if (idx >= IDX_FRF_HI && idx <= IDX_FRF_LO) begin
         k = K_FRF;
      end else if (idx >= IDX_PAGE_LO && idx <= IDX_PAGE_HI) begin
         k = K_PAGE;
      end else if (idx >= IDX_BAND_LO && idx <= IDX_BAND_HI) begin
         k = K_BAND;
      end
      return k;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Payload FIFOs
   logic tx_in_valid;
   logic tx_in_ready;
   logic [BYTE_W-1:0] rx_out_data;
   logic rx_out_valid;
   logic rx_out_ready;
   logic [BYTE_W-1:0] wr_byte;

   // Sleep holds both FIFOs empty
   lrrp_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .clk(clk),
      .reset_n(reset_n),
      .flush(sleeping),
      .in_data(wr_byte),
      .in_valid(tx_in_valid),
      .in_ready(tx_in_ready),
      .out_data(pay_tx_data),
      .out_valid(pay_tx_valid),
      .out_ready(pay_tx_ready)
   );

   lrrp_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .clk(clk),
      .reset_n(reset_n),
      .flush(sleeping),
      .in_data(pay_rx_data),
      .in_valid(pay_rx_valid),
      .in_ready(pay_rx_ready),
      .out_data(rx_out_data),
      .out_valid(rx_out_valid),
      .out_ready(rx_out_ready)
   );

   ////////////////////////////////////////////////////////////////////////
   // Write channel: address and data latched independently
   logic aw_held_r;
   logic [IDX_W-1:0] aw_idx_r;
   logic w_held_r;
   logic [BYTE_W-1:0] w_data_r;
   logic w_lane0_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   lrrp_kind_t wr_kind;
   logic wr_stall;
   logic wr_go;
   logic wr_en;

   assign s_axi_awready = !aw_held_r;
   assign s_axi_wready = !w_held_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign wr_kind = decode(aw_idx_r);
   assign wr_byte = w_data_r;
   // Full FIFO holds the response back instead of dropping bytes
   assign wr_stall = (wr_kind == K_FIFO) && !sleeping && !tx_in_ready;
   assign wr_go = aw_held_r && w_held_r && !bvalid_r && !wr_stall;
   assign wr_en = wr_go && w_lane0_r;
   assign tx_in_valid = wr_en && (wr_kind == K_FIFO) && !sleeping;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_held_r <= 1'b0;
         aw_idx_r <= '0;
      end else if (s_axi_awvalid && !aw_held_r) begin
         aw_held_r <= 1'b1;
         aw_idx_r <= s_axi_awaddr[ADDR_W-1:2];
      end else if (wr_go) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         w_held_r <= 1'b0;
         w_data_r <= '0;
         w_lane0_r <= 1'b0;
      end else if (s_axi_wvalid && !w_held_r) begin
         w_held_r <= 1'b1;
         w_data_r <= s_axi_wdata[BYTE_W-1:0];
         w_lane0_r <= s_axi_wstrb[0];
      end else if (wr_go) begin
         w_held_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r <= (wr_kind == K_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Operating-mode register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         family_r <= FAMILY_RST;
         shared_r <= SHARED_RST;
         band_r <= BAND_RST;
         state_r <= STATE_RST;
         state_change_r <= 1'b0;
      end else begin
         state_change_r <= 1'b0;
         if (wr_en && wr_kind == K_OPMODE) begin
            // Judged on the state before this write
            if (sleeping) begin
               family_r <= wr_byte[OPM_FAMILY_BIT];
            end
            shared_r <= wr_byte[OPM_SHARED_BIT];
            band_r <= wr_byte[OPM_BAND_BIT];
            state_r <= lrrp_state_t'(wr_byte[OPM_STATE_MSB:0]);
            state_change_r <= 1'b1;
         end
      end
   end

   assign state_change = state_change_r;

   ////////////////////////////////////////////////////////////////////////
   // Carrier word, one copy per modem family
   logic [1:0] wr_frf_off;
   assign wr_frf_off = 2'(aw_idx_r - IDX_FRF_HI);

   // Write allowed in any state; the host keeps it to sleep or standby
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int f = 0; f < 2; f++) begin
            frf_r[f][0] <= FRF_HI_RST;
            frf_r[f][1] <= FRF_MID_RST;
            frf_r[f][2] <= FRF_LO_RST;
         end
      end else if (wr_en && wr_kind == K_FRF) begin
         frf_r[family_r][wr_frf_off] <= wr_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Paged and band-specific storage
   logic [PAGE_AW-1:0] wr_pg_off;
   logic [BAND_AW-1:0] wr_bd_off;
   assign wr_pg_off = PAGE_AW'(aw_idx_r - IDX_PAGE_LO);
   assign wr_bd_off = BAND_AW'(aw_idx_r - IDX_BAND_LO);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < PAGE_N; i++) begin
               page_r[p][i] <= PAGE_RST;
            end
         end
      end else if (wr_en && wr_kind == K_PAGE) begin
         page_r[page_sel][wr_pg_off] <= wr_byte;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int b = 0; b < 2; b++) begin
            for (int i = 0; i < BAND_N; i++) begin
               band_mem_r[b][i] <= PAGE_RST;
            end
         end
      end else if (wr_en && wr_kind == K_BAND) begin
         band_mem_r[band_r][wr_bd_off] <= wr_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read channel: address taken, data one cycle later
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic ar_hs;
   logic [IDX_W-1:0] rd_idx;
   lrrp_kind_t rd_kind;
   logic [BYTE_W-1:0] rd_byte;
   logic [1:0] rd_frf_off;
   logic [PAGE_AW-1:0] rd_pg_off;
   logic [BAND_AW-1:0] rd_bd_off;

   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign ar_hs = s_axi_arvalid && !rvalid_r;
   assign rd_idx = s_axi_araddr[ADDR_W-1:2];
   assign rd_kind = decode(rd_idx);
   assign rd_frf_off = 2'(rd_idx - IDX_FRF_HI);
   assign rd_pg_off = PAGE_AW'(rd_idx - IDX_PAGE_LO);
   assign rd_bd_off = BAND_AW'(rd_idx - IDX_BAND_LO);
   // Each read of the port outside sleep consumes one received byte if one waits
   assign rx_out_ready = ar_hs && (rd_kind == K_FIFO) && !sleeping;

   always_comb begin
      rd_byte = 8'h00;
      case (rd_kind)
         K_FIFO: begin
            if (!sleeping && rx_out_valid) begin
               rd_byte = rx_out_data;
            end
         end
         K_OPMODE: begin
            rd_byte[OPM_FAMILY_BIT] = family_r;
            rd_byte[OPM_SHARED_BIT] = shared_r;
            rd_byte[OPM_BAND_BIT] = band_r;
            rd_byte[OPM_STATE_MSB:0] = state_r;
         end
         K_FRF: begin
            rd_byte = frf_r[family_r][rd_frf_off];
         end
         K_PAGE: begin
            rd_byte = page_r[page_sel][rd_pg_off];
         end
         K_BAND: begin
            rd_byte = band_mem_r[band_r][rd_bd_off];
         end
         default: begin
            rd_byte = 8'h00;
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_r <= 1'b1;
         rdata_r <= {24'h000000, rd_byte};
         rresp_r <= (rd_kind == K_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration toward the radio follows the active family
   always_comb begin
      cfg.modem_family_select = family_r;
      cfg.shared_page_window_enable = shared_r;
      cfg.band_bank_select = band_r;
      cfg.op_state = state_r;
      cfg.carrier_freq = {frf_r[family_r][0], frf_r[family_r][1],
                          frf_r[family_r][2]};
   end
endmodule

// ### verif/lrrp_regs_props.sv
// Concurrent checks on the ports of the long-range register page.
// Assumes it is bound to lrrp_regs, whose ports it shares by name.
`timescale 1ns/1ps
module lrrp_regs_props
   import lrrp_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register bus
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_bvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   // Payload streams
   input wire logic [BYTE_W-1:0] pay_tx_data,
   input wire logic pay_tx_valid,
   input wire logic pay_tx_ready,
   input wire logic pay_rx_ready,
   // Radio configuration
   input wire lrrp_cfg_t cfg,
   input wire logic state_change
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   ////////////////////////////////////////////////////////////////////////
   family_lock_a: assert property (
      $changed(cfg.modem_family_select) |-> $past(cfg.op_state) == ST_SLEEP)
      else $error("modem family changed outside sleep");
   state_write_a: assert property (
      $changed(cfg.op_state) |-> $rose(s_axi_bvalid))
      else $error("operating state changed without a write");
   cfg_write_a: assert property (
      $changed(cfg.carrier_freq) || $changed(cfg.band_bank_select)
      |-> $rose(s_axi_bvalid))
      else $error("configuration changed without a write");
   state_pulse_a: assert property (
      state_change |=> !state_change)
      else $error("state change pulse longer than one cycle");
   sleep_fifo_a: assert property (
      cfg.op_state == ST_SLEEP && $past(cfg.op_state) == ST_SLEEP
      |-> !pay_tx_valid && !pay_rx_ready)
      else $error("payload stream active in sleep");
   read_fmt_a: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 &&
      (s_axi_rresp != RESP_SLVERR || s_axi_rdata == 32'h0))
      else $error("read data outside the low byte");
   tx_hold_a: assert property (
      pay_tx_valid && !pay_tx_ready |=> (pay_tx_valid &&
      $stable(pay_tx_data)) || cfg.op_state == ST_SLEEP)
      else $error("transmit byte dropped while stalled");
   read_one_a: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");

   cover property (state_change && cfg.modem_family_select);
   cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
   cover property (pay_tx_valid && !pay_tx_ready);
endmodule

// ### verif/lrrp_modem_model.sv
// Behavioural modem on the payload streams of the register page.
// Assumes the bench fills sent_q and reads got_q by hierarchy.
`timescale 1ns/1ps
module lrrp_modem_model
   import lrrp_pkg::*;
(
   // Clock, reset and back-pressure
   input wire logic clk,
   input wire logic reset_n,
   input wire logic stall,
   // Bytes leaving the transmit FIFO
   input wire logic [BYTE_W-1:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   // Bytes entering the receive FIFO
   output logic [BYTE_W-1:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready
);
   logic [BYTE_W-1:0] sent_q [$];
   logic [BYTE_W-1:0] got_q [$];

   ////////////////////////////////////////////////////////////////////////
   // Idle data toggles so a stale byte never passes for a fresh one
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_ready <= 1'b0;
         rx_valid <= 1'b0;
         rx_data <= 8'hA5;
      end else begin
         if (tx_valid && tx_ready) begin
            got_q.push_back(tx_data);
         end
         tx_ready <= !stall;
         if (rx_valid && rx_ready) begin
            void'(sent_q.pop_front());
         end
         rx_valid <= sent_q.size() != 0;
         rx_data <= sent_q.size() != 0 ? sent_q[0] : ~rx_data;
      end
   end
endmodule

// ### verif/long_range_mode_register_page_tb.sv
// Self-checking bench for the long-range register page.
// Assumes the props checker and modem model are compiled alongside.
`timescale 1ns/1ps
module long_range_mode_register_page_tb
   import lrrp_pkg::*;
;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic stall = 1'b1, rnd_on = 1'b0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = '0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, pay_tx_valid, pay_tx_ready, pay_rx_valid;
   logic pay_rx_ready, state_change;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [BYTE_W-1:0] pay_tx_data, pay_rx_data;
   lrrp_cfg_t cfg;
   int errors = 0, checks = 0;
   integer seed = 32'h1D27766F;

   always #5 clk = ~clk;
   always @(posedge clk) stall <= !rnd_on || ($random(seed) & 3) == 0;

   lrrp_regs DUT (.clk(clk), .reset_n(reset_n),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .pay_tx_data(pay_tx_data),
      .pay_tx_valid(pay_tx_valid), .pay_tx_ready(pay_tx_ready),
      .pay_rx_data(pay_rx_data), .pay_rx_valid(pay_rx_valid),
      .pay_rx_ready(pay_rx_ready), .cfg(cfg), .state_change(state_change));

   lrrp_modem_model MODEM (.clk(clk), .reset_n(reset_n), .stall(stall),
      .tx_data(pay_tx_data), .tx_valid(pay_tx_valid),
      .tx_ready(pay_tx_ready), .rx_data(pay_rx_data),
      .rx_valid(pay_rx_valid), .rx_ready(pay_rx_ready));

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] opm(input logic f, s, b,
                                      input logic [2:0] st);
      return {f, s, 2'b00, b, st};
   endfunction

   function automatic logic [7:0] rst_val(input int i);
      case (i)
         1: return 8'h09;
         6: return FRF_HI_RST;
         7: return FRF_MID_RST;
         8: return FRF_LO_RST;
         default: return 8'h00;
      endcase
   endfunction

   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      checks++;
      if (g !== e) begin
         errors++;
         $display("Error at %0t: got %h, expected %h", $time, g, e);
      end
   endtask

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Each wait ends only on the slave's answer; the watchdog cuts hangs
   // Ready lines stay high between transfers, so back-to-back calls
   // never assign them twice in one time step
   task automatic wr(input logic [6:0] i, input logic [7:0] d,
                     input logic [1:0] er = RESP_OKAY,
                     input logic [3:0] sb = 4'hF);
      s_axi_awaddr <= {i, 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= sb;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      chk({32'h0, s_axi_bresp}, {32'h0, er});
      // Pulse rises with the response
      if (i == IDX_OPMODE) chk({33'h0, state_change}, {33'h0, sb[0]});
   endtask

   task automatic rc(input logic [6:0] i, input logic [7:0] e,
                     input logic [1:0] er = RESP_OKAY);
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      chk({s_axi_rresp, s_axi_rdata}, {er, 24'h0, e});
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] v [6];
      logic [7:0] q [$];
      for (int k = 0; k < 6; k++) v[k] = 8'($random(seed)) | 8'h01;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      for (int k = 1; k < 9; k++) rc(7'(k), rst_val(k));
      for (int k = 2; k < 6; k++) begin
         wr(7'(k), v[k]);
         rc(7'(k), 8'h00);
      end
      wr(7'h01, 8'h39);
      rc(7'h01, opm(0, 0, 1, 1));
      wr(7'h09, v[0], RESP_SLVERR);
      rc(7'h40, 8'h00, RESP_SLVERR);
      wr(7'h01, opm(1, 0, 1, 1));
      rc(7'h01, opm(0, 0, 1, 1));
      wr(7'h01, opm(0, 0, 1, 0));
      wr(7'h01, opm(1, 0, 1, 0));
      rc(7'h01, opm(1, 0, 1, 0));
      wr(7'h01, opm(1, 0, 1, 1));
      wr(7'h01, opm(0, 0, 1, 1));
      rc(7'h01, opm(1, 0, 1, 1));
      wr(7'h06, v[0]);
      wr(7'h0D, v[1]);
      wr(7'h01, opm(1, 1, 1, 1));
      rc(7'h0D, 8'h00);
      wr(7'h0D, v[2]);
      wr(7'h3F, v[3]);
      wr(7'h01, opm(1, 0, 1, 1));
      rc(7'h0D, v[1]);
      rc(7'h3F, 8'h00);
      // Strobe lane 0 low: the write is answered but changes nothing
      wr(7'h07, v[1], RESP_OKAY, 4'h0);
      rc(7'h07, FRF_MID_RST);
      chk({10'h0, cfg.carrier_freq},
          {10'h0, v[0], FRF_MID_RST, FRF_LO_RST});
      wr(7'h61, v[4]);
      wr(7'h01, opm(1, 0, 0, 1));
      rc(7'h61, 8'h00);
      wr(7'h61, v[5]);
      wr(7'h01, opm(1, 0, 1, 1));
      rc(7'h61, v[4]);
      wr(7'h01, opm(1, 0, 1, 0));
      wr(7'h01, opm(0, 0, 1, 0));
      rc(7'h0D, v[2]);
      rc(7'h3F, v[3]);
      rc(7'h06, FRF_HI_RST);
      for (int s = 0; s < 8; s++) begin
         wr(7'h01, opm(0, 0, 1, 3'(s)));
         rc(7'h01, opm(0, 0, 1, 3'(s)));
      end
      wr(7'h01, opm(0, 0, 1, 1));
      // Modem stalls until the seventeenth write has to wait for room
      fork
         begin
            repeat (60) @(posedge clk);
            rnd_on <= 1'b1;
         end
      join_none
      for (int k = 0; k < 17; k++) begin
         q.push_back(8'($random(seed)));
         wr(7'h00, q[k]);
      end
      for (int t = 0; t < 200 && MODEM.got_q.size() < 17; t++) @(posedge clk);
      foreach (q[k]) chk({26'h0, MODEM.got_q[k]}, {26'h0, q[k]});
      @(negedge clk);
      for (int k = 0; k < 3; k++) MODEM.sent_q.push_back(v[k]);
      repeat (10) @(posedge clk);
      for (int k = 0; k < 3; k++) rc(7'h00, v[k]);
      rc(7'h00, 8'h00);
      @(negedge clk);
      MODEM.sent_q.push_back(v[4]);
      repeat (10) @(posedge clk);
      wr(7'h01, opm(0, 0, 1, 0));
      wr(7'h00, v[5]);
      rc(7'h00, 8'h00);
      wr(7'h01, opm(0, 0, 1, 1));
      repeat (10) @(posedge clk);
      rc(7'h00, 8'h00);
      chk(34'(MODEM.got_q.size()), 34'h11);
      close_out();
   end
endmodule

bind lrrp_regs lrrp_regs_props CHK (.*);
